//--- rtl/spf_defs.svh
// Register map, field positions, reset values and codes of the serial port.
// Assumes it is included by name wherever a constant is needed.
`ifndef SPF_DEFS_SVH
`define SPF_DEFS_SVH

// ==========================================
// Register byte offsets (low address bits)
`define SPF_ADDR_CTRL 4'h0
`define SPF_ADDR_STAT 4'h4
`define SPF_ADDR_TXD 4'h8
`define SPF_ADDR_RXD 4'hC

// ==========================================
// Control word
`define SPF_CTRL_W 11
`define SPF_CTRL_RESET 11'h008

// ==========================================
// Status bits, sticky ones cleared by writing one
`define SPF_ST_OVR 3
`define SPF_ST_PERR 4
`define SPF_ST_FERR 5

// ==========================================
// Flow codes and line rates
`define SPF_XON 8'h11
`define SPF_XOFF 8'h13
`define SPF_CLK_HZ 125000000
`define SPF_BAUD_0 9600
`define SPF_BAUD_1 19200
`define SPF_BAUD_2 38400
`define SPF_BAUD_3 57600
`define SPF_BAUD_4 115200
`define SPF_FIFO_DEPTH 8

`endif

//--- rtl/spf_fifo.sv
// Flip-flop FIFO with valid and ready on both sides.
// Assumes one clock, an active-low asynchronous reset and a clock enable.
`timescale 1ns/1ns
module spf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // Filling side
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    // Draining side
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] rd;
        logic [AW-1:0] wr;
        logic [AW:0] cnt;
    } spf_fifo_s;

    spf_fifo_s s_reg, s_next;
    logic push, pop;

    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad
            $error("FIFO depth must be a power of two of at least two");
        end
    endgenerate

    assign in_ready_o = s_reg.cnt != (AW+1)'(DEPTH);
    assign out_valid_o = s_reg.cnt != '0;
    assign out_data_o = s_reg.mem[s_reg.rd];

    always_comb begin
        s_next = s_reg;
        push = in_valid_i && in_ready_o;
        pop = out_valid_o && out_ready_i;
        if (push) begin
            s_next.mem[s_reg.wr] = in_data_i;
            s_next.wr = s_reg.wr + 1'b1;
        end
        if (pop) begin
            s_next.rd = s_reg.rd + 1'b1;
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end
endmodule

//--- rtl/spf_pkg.sv
// Types shared by the serial port and its host model.
// Assumes nothing of its surroundings.
package spf_pkg;

    // ==========================================
    // Frame options
    typedef enum logic [1:0] {
        SPF_PAR_NONE = 2'b00,
        SPF_PAR_EVEN = 2'b01,
        SPF_PAR_ODD = 2'b10
    } spf_par_e;

    typedef enum logic [1:0] {
        SPF_FLOW_NONE = 2'b00,
        SPF_FLOW_SW = 2'b01,
        SPF_FLOW_HW = 2'b10
    } spf_flow_e;

    // Bit 10 down to bit 0 of the control register
    typedef struct packed {
        logic busy;
        logic ready;
        spf_flow_e flow;
        spf_par_e par;
        logic two_stop;
        logic eight;
        logic [2:0] baud;
    } spf_ctrl_s;

    // ==========================================
    // Line engine states
    typedef enum logic [2:0] {
        SPF_LN_IDLE = 3'b000,
        SPF_LN_START = 3'b001,
        SPF_LN_DATA = 3'b010,
        SPF_LN_PAR = 3'b011,
        SPF_LN_STOP = 3'b100
    } spf_ln_e;

endpackage

//--- rtl/spf_uart.sv
// Serial port with software and hardware flow control, AHB-Lite registers.
// Assumes a 125 MHz clock, a single-master AHB-Lite bus, RS-232 drivers
// outside that turn line levels into plain logic (high = mark/asserted).
//
// What this block does
// - The line runs at 9600, 19200, 38400, 57600 or 115200 bit/s.
// - A frame carries seven or eight data bits, as configured.
// - Software flow sends resume 11h or pause 13h as characters.
// - Software flow sends the pause code when the printer turns busy.
// - Software flow sends the resume code when busy is left.
// - Hardware flow samples clear-to-send before each character.
// - Hardware flow holds transmission while the host is busy.
// - Request-to-send shows the printer is ready for data.
// - Terminal-ready follows request-to-send.
// - Data-set-ready carries a second host readiness, needed together with CTS.
`timescale 1ns/1ns
`include "spf_defs.svh"
module spf_uart #(
    parameter int CLK_HZ = `SPF_CLK_HZ,
    parameter int FIFO_DEPTH = `SPF_FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic reset_n_i,
    input wire logic ce_i,
    // AHB-Lite slave
    input wire logic hsel_i,
    input wire logic [31:0] haddr_i,
    input wire logic [1:0] htrans_i,
    input wire logic hwrite_i,
    input wire logic [2:0] hsize_i,
    input wire logic [31:0] hwdata_i,
    input wire logic hready_i,
    output logic [31:0] hrdata_o,
    output logic hreadyout_o,
    output logic hresp_o,
    // Serial line
    input wire logic rxd_i,
    input wire logic cts_i,
    input wire logic dsr_i,
    output logic txd_o,
    output logic rts_o,
    output logic dtr_o
);
    // ==========================================
    // State
    typedef struct packed {
        spf_pkg::spf_ctrl_s ctrl;
        logic [1:0] cts_sy;
        logic [1:0] dsr_sy;
        logic [1:0] rxd_sy;
        logic pend;
        logic pend_wr;
        logic pend_hit;
        logic [3:0] pend_addr;
        logic hready;
        logic hresp;
        logic [31:0] hrdata;
        spf_pkg::spf_ln_e tx_st;
        logic [15:0] tx_cnt;
        logic [3:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic txd;
        logic xoff_sent;
        spf_pkg::spf_ln_e rx_st;
        logic [15:0] rx_cnt;
        logic [3:0] rx_bit;
        logic [7:0] rx_sh;
        logic [7:0] rx_data;
        logic rx_valid;
        logic ovr;
        logic perr;
        logic ferr;
    } spf_state_s;

    spf_state_s s_reg, s_next;
    logic host_rdy, rxd, tx_go, fifo_pop, fifo_push, stall;
    logic fifo_in_rdy, fifo_out_vld;
    logic [7:0] fifo_out, tx_byte, rx_byte;
    logic [15:0] div;

    // ==========================================
    // Helpers
    function automatic logic [15:0] baud_div(input logic [2:0] sel);
        int rate;
        case (sel)
            3'h0: rate = `SPF_BAUD_0;
            3'h1: rate = `SPF_BAUD_1;
            3'h2: rate = `SPF_BAUD_2;
            3'h3: rate = `SPF_BAUD_3;
            default: rate = `SPF_BAUD_4;
        endcase
        return 16'(CLK_HZ / rate);
    endfunction

    // Parity over the active data bits; odd inverts the even result
    function automatic logic par_of(input logic [7:0] d,
                                    input spf_pkg::spf_ctrl_s c);
        logic p;
        p = ^{d[7] & c.eight, d[6:0]};
        return p ^ (c.par == spf_pkg::SPF_PAR_ODD);
    endfunction

    generate
        if (CLK_HZ / `SPF_BAUD_0 > 65535 || CLK_HZ / `SPF_BAUD_4 < 4)
        begin : g_bad_clk
            $error("Clock rate gives no usable bit divisor");
        end
    endgenerate

    // Transmit buffer: a full buffer stalls the bus write
    spf_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_txq (
        .clk_i(clk_i),
        .reset_n_i(reset_n_i),
        .ce_i(ce_i),
        .in_valid_i(fifo_push),
        .in_data_i(hwdata_i[7:0]),
        .in_ready_o(fifo_in_rdy),
        .out_valid_o(fifo_out_vld),
        .out_data_o(fifo_out),
        .out_ready_i(fifo_pop)
    );

    assign txd_o = s_reg.txd;
    assign rts_o = s_reg.ctrl.ready;
    assign dtr_o = s_reg.ctrl.ready;
    assign hrdata_o = s_reg.hrdata;
    assign hreadyout_o = s_reg.hready;
    assign hresp_o = s_reg.hresp;

    always_comb begin
        s_next = s_reg;
        fifo_push = 1'b0;
        fifo_pop = 1'b0;
        stall = 1'b0;
        tx_go = 1'b0;
        tx_byte = 8'h00;
        div = baud_div(s_reg.ctrl.baud);
        s_next.cts_sy = {s_reg.cts_sy[0], cts_i};
        s_next.dsr_sy = {s_reg.dsr_sy[0], dsr_i};
        s_next.rxd_sy = {s_reg.rxd_sy[0], rxd_i};
        rxd = s_reg.rxd_sy[1];
        host_rdy = s_reg.cts_sy[1] && s_reg.dsr_sy[1];
        rx_byte = s_reg.ctrl.eight ? s_reg.rx_sh : {1'b0, s_reg.rx_sh[7:1]};

        // ==========================================
        // Bus data phase; one wait state at least
        if (s_reg.pend) begin
            s_next.hrdata = 32'h0000_0000;
            if (s_reg.pend_hit) begin
                case (s_reg.pend_addr)
                    `SPF_ADDR_CTRL: begin
                        if (s_reg.pend_wr) begin
                            s_next.ctrl = hwdata_i[`SPF_CTRL_W-1:0];
                        end else begin
                            s_next.hrdata = {21'h0, s_reg.ctrl};
                        end
                    end
                    `SPF_ADDR_STAT: begin
                        if (s_reg.pend_wr) begin
                            s_next.ovr = s_reg.ovr && !hwdata_i[`SPF_ST_OVR];
                            s_next.perr = s_reg.perr && !hwdata_i[`SPF_ST_PERR];
                            s_next.ferr = s_reg.ferr && !hwdata_i[`SPF_ST_FERR];
                        end else begin
                            s_next.hrdata = {22'h0, s_reg.xoff_sent,
                                s_reg.tx_st != spf_pkg::SPF_LN_IDLE,
                                s_reg.dsr_sy[1], s_reg.cts_sy[1],
                                s_reg.ferr, s_reg.perr, s_reg.ovr,
                                !fifo_out_vld, !fifo_in_rdy, s_reg.rx_valid};
                        end
                    end
                    `SPF_ADDR_TXD: begin
                        if (s_reg.pend_wr) begin
                            fifo_push = fifo_in_rdy;
                            stall = !fifo_in_rdy;
                        end
                    end
                    `SPF_ADDR_RXD: begin
                        if (!s_reg.pend_wr) begin
                            s_next.hrdata = {24'h0, s_reg.rx_data};
                            s_next.rx_valid = 1'b0;
                        end
                    end
                    default: begin
                    end
                endcase
            end
            if (!stall) begin
                s_next.pend = 1'b0;
                s_next.hready = 1'b1;
            end
        end else if (hsel_i && htrans_i[1] && hready_i) begin
            s_next.pend = 1'b1;
            s_next.pend_wr = hwrite_i;
            s_next.pend_hit = haddr_i[31:4] == 28'h0 && haddr_i[1:0] == 2'h0;
            s_next.pend_addr = haddr_i[3:0];
            s_next.hready = 1'b0;
        end

        // ==========================================
        // Transmitter; flow codes go ahead of queued data
        if (s_reg.tx_st != spf_pkg::SPF_LN_IDLE && s_reg.tx_cnt != 16'h0) begin
            s_next.tx_cnt = s_reg.tx_cnt - 16'h1;
        end else begin
            s_next.tx_cnt = div - 16'h1;
            case (s_reg.tx_st)
                spf_pkg::SPF_LN_IDLE: begin
                    s_next.txd = 1'b1;
                    if (s_reg.ctrl.flow == spf_pkg::SPF_FLOW_SW &&
                        s_reg.xoff_sent != s_reg.ctrl.busy) begin
                        tx_go = 1'b1;
                        tx_byte = s_reg.ctrl.busy ? `SPF_XOFF : `SPF_XON;
                        s_next.xoff_sent = s_reg.ctrl.busy;
                    end else if (fifo_out_vld &&
                        (s_reg.ctrl.flow != spf_pkg::SPF_FLOW_HW || host_rdy)) begin
                        tx_go = 1'b1;
                        tx_byte = fifo_out;
                        fifo_pop = 1'b1;
                    end
                    if (tx_go) begin
                        s_next.tx_st = spf_pkg::SPF_LN_START;
                        s_next.txd = 1'b0;
                        s_next.tx_sh = tx_byte;
                        s_next.tx_par = par_of(tx_byte, s_reg.ctrl);
                    end
                end
                spf_pkg::SPF_LN_START: begin
                    s_next.tx_st = spf_pkg::SPF_LN_DATA;
                    s_next.tx_bit = 4'h0;
                    s_next.txd = s_reg.tx_sh[0];
                    s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
                end
                spf_pkg::SPF_LN_DATA: begin
                    if (s_reg.tx_bit == (s_reg.ctrl.eight ? 4'h7 : 4'h6)) begin
                        s_next.tx_bit = 4'h0;
                        if (s_reg.ctrl.par != spf_pkg::SPF_PAR_NONE) begin
                            s_next.tx_st = spf_pkg::SPF_LN_PAR;
                            s_next.txd = s_reg.tx_par;
                        end else begin
                            s_next.tx_st = spf_pkg::SPF_LN_STOP;
                            s_next.txd = 1'b1;
                        end
                    end else begin
                        s_next.tx_bit = s_reg.tx_bit + 4'h1;
                        s_next.txd = s_reg.tx_sh[0];
                        s_next.tx_sh = {1'b0, s_reg.tx_sh[7:1]};
                    end
                end
                spf_pkg::SPF_LN_PAR: begin
                    s_next.tx_st = spf_pkg::SPF_LN_STOP;
                    s_next.txd = 1'b1;
                end
                spf_pkg::SPF_LN_STOP: begin
                    if (s_reg.ctrl.two_stop && s_reg.tx_bit == 4'h0) begin
                        s_next.tx_bit = 4'h1;
                    end else begin
                        s_next.tx_st = spf_pkg::SPF_LN_IDLE;
                    end
                end
                default: begin
                    s_next.tx_st = spf_pkg::SPF_LN_IDLE;
                end
            endcase
        end

        // ==========================================
        // Receiver: samples each bit at its middle
        if (s_reg.rx_st != spf_pkg::SPF_LN_IDLE && s_reg.rx_cnt != 16'h0) begin
            s_next.rx_cnt = s_reg.rx_cnt - 16'h1;
        end else begin
            s_next.rx_cnt = div - 16'h1;
            case (s_reg.rx_st)
                spf_pkg::SPF_LN_IDLE: begin
                    if (!rxd) begin
                        s_next.rx_st = spf_pkg::SPF_LN_START;
                        s_next.rx_cnt = {1'b0, div[15:1]};
                    end
                end
                spf_pkg::SPF_LN_START: begin
                    // A glitch shorter than half a bit is dropped
                    s_next.rx_st = rxd ? spf_pkg::SPF_LN_IDLE : spf_pkg::SPF_LN_DATA;
                    s_next.rx_bit = 4'h0;
                end
                spf_pkg::SPF_LN_DATA: begin
                    s_next.rx_sh = {rxd, s_reg.rx_sh[7:1]};
                    s_next.rx_bit = s_reg.rx_bit + 4'h1;
                    if (s_reg.rx_bit == (s_reg.ctrl.eight ? 4'h7 : 4'h6)) begin
                        s_next.rx_st = s_reg.ctrl.par == spf_pkg::SPF_PAR_NONE ?
                            spf_pkg::SPF_LN_STOP : spf_pkg::SPF_LN_PAR;
                    end
                end
                spf_pkg::SPF_LN_PAR: begin
                    s_next.rx_st = spf_pkg::SPF_LN_STOP;
                    if (rxd != par_of(rx_byte, s_reg.ctrl)) begin
                        s_next.perr = 1'b1;
                    end
                end
                spf_pkg::SPF_LN_STOP: begin
                    // Hardware set wins over a clear in the same cycle
                    s_next.rx_st = spf_pkg::SPF_LN_IDLE;
                    s_next.ferr = s_next.ferr || !rxd;
                    s_next.ovr = s_next.ovr || s_next.rx_valid;
                    s_next.rx_data = rx_byte;
                    s_next.rx_valid = 1'b1;
                end
                default: begin
                    s_next.rx_st = spf_pkg::SPF_LN_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            s_reg <= '0;
            s_reg.ctrl <= `SPF_CTRL_RESET;
            s_reg.cts_sy <= 2'h0;
            s_reg.dsr_sy <= 2'h0;
            s_reg.rxd_sy <= 2'h3;
            s_reg.hready <= 1'b1;
            s_reg.txd <= 1'b1;
        end else if (ce_i) begin
            s_reg <= s_next;
        end
    end

    // ==========================================
    // Checks
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!reset_n_i);

    sequence tx_launch;
        ce_i && s_reg.tx_st == spf_pkg::SPF_LN_IDLE && tx_go;
    endsequence

    sequence pause_due;
        s_reg.ctrl.flow == spf_pkg::SPF_FLOW_SW && s_reg.ctrl.busy &&
        !s_reg.xoff_sent;
    endsequence

    bit_timer_a: assert property (s_reg.tx_cnt < CLK_HZ / 9600)
        else $error("bit timer beyond slowest rate");
    data_count_a: assert property (ce_i &&
        s_reg.tx_st == spf_pkg::SPF_LN_DATA &&
        s_next.tx_st != spf_pkg::SPF_LN_DATA |->
        s_reg.tx_bit == (s_reg.ctrl.eight ? 4'h7 : 4'h6))
        else $error("wrong number of data bits");
    stop_level_a: assert property (
        s_reg.tx_st == spf_pkg::SPF_LN_STOP |->
        txd_o && s_reg.ctrl.par != 2'h3)
        else $error("stop bit not at mark");
    pause_code_a: assert property (tx_launch and pause_due |=>
        s_reg.tx_sh == `SPF_XOFF && s_reg.xoff_sent && !txd_o)
        else $error("pause code not sent");
    resume_code_a: assert property (tx_launch and
        (s_reg.xoff_sent && !s_reg.ctrl.busy &&
        s_reg.ctrl.flow == spf_pkg::SPF_FLOW_SW) |=>
        s_reg.tx_sh == `SPF_XON && !s_reg.xoff_sent)
        else $error("resume code not sent");
    hw_hold_a: assert property (ce_i && !host_rdy &&
        s_reg.ctrl.flow == spf_pkg::SPF_FLOW_HW &&
        s_reg.tx_st == spf_pkg::SPF_LN_IDLE |=>
        s_reg.tx_st == spf_pkg::SPF_LN_IDLE && txd_o)
        else $error("sent while host busy");
    cts_dsr_a: assert property (tx_launch and
        s_reg.ctrl.flow == spf_pkg::SPF_FLOW_HW |->
        s_reg.cts_sy[1] && s_reg.dsr_sy[1])
        else $error("start without host ready");
    ready_pair_a: assert property (rts_o == dtr_o)
        else $error("ready lines differ");
    full_stall_a: assert property (s_reg.pend && s_reg.pend_wr &&
        s_reg.pend_hit && s_reg.pend_addr == `SPF_ADDR_TXD &&
        !fifo_in_rdy |=> !hreadyout_o)
        else $error("write to full buffer not stalled");
endmodule

//--- sim/spf_host.sv
// Host model: reads the port's frames, sends frames back, shows readiness.
// Assumes the bench gives it the same frame format as the port.
`timescale 1ns/1ns
module spf_host #(
    parameter int CLK_HZ = 1152000
) (
    // Clock and format
    input wire logic clk_i,
    input wire logic [10:0] cfg_i,
    input wire logic [1:0] busy_i,
    // Line
    input wire logic txd_i,
    output logic rxd_o,
    output logic cts_o,
    output logic dsr_o,
    // Last frame seen
    output logic [7:0] got_o,
    output logic bad_o,
    output logic paused_o,
    output int count_o
);
    spf_pkg::spf_ctrl_s c;
    logic [7:0] v;
    logic p;
    logic ok;
    int d;
    assign c = cfg_i;
    // Busy on either line must hold the port off
    assign cts_o = ~busy_i[0];
    assign dsr_o = ~busy_i[1];
    initial begin
        rxd_o = 1'b1;
        paused_o = 1'b0;
        count_o = 0;
    end
    // Reserved rate codes run at the top rate
    function automatic int bit_len();
        case (c.baud)
            3'h0: return CLK_HZ / 9600;
            3'h1: return CLK_HZ / 19200;
            3'h2: return CLK_HZ / 38400;
            3'h3: return CLK_HZ / 57600;
            default: return CLK_HZ / 115200;
        endcase
    endfunction
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
    endtask
    // ==========================================
    // Receive, LSB first, sampled mid-bit
    always begin
        @(negedge txd_i);
        d = bit_len();
        tick(d / 2);
        ok = (txd_i === 1'b0);
        p = c.par[1];
        v = 8'h00;
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || c.eight) begin
                tick(d);
                v[i] = txd_i;
                p = p ^ txd_i;
            end
        end
        if (c.par != spf_pkg::SPF_PAR_NONE) begin
            tick(d);
            ok = ok && (txd_i === p);
        end
        tick(d);
        ok = ok && (txd_i === 1'b1);
        if (c.two_stop) begin
            tick(d);
            ok = ok && (txd_i === 1'b1);
        end
        got_o = v;
        bad_o = !ok;
        // Pause stops our sending, resume frees it
        if (v == 8'h13) paused_o = 1'b1;
        if (v == 8'h11) paused_o = 1'b0;
        count_o++;
    end
    // ==========================================
    // Send one frame, after waiting up to 50000 cycles for a pause to end
    task automatic send(input logic [7:0] b);
        int n;
        int dd;
        logic q;
        n = 0;
        while (paused_o && n < 50000) begin
            @(posedge clk_i);
            n++;
        end
        // Still paused at the bound: the port never resumed
        if (paused_o) tb.miscompares++;
        dd = bit_len();
        q = c.par[1];
        rxd_o <= 1'b0;
        tick(dd);
        for (int i = 0; i < 8; i++) begin
            if (i < 7 || c.eight) begin
                rxd_o <= b[i];
                q = q ^ b[i];
                tick(dd);
            end
        end
        if (c.par != spf_pkg::SPF_PAR_NONE) begin
            rxd_o <= q;
            tick(dd);
        end
        rxd_o <= 1'b1;
        tick(c.two_stop ? 2 * dd : dd);
    endtask
endmodule

//--- sim/tb.sv
// Bench: drives the port over its bus and talks to the host model.
// Assumes the design files and the host model are compiled first.
`timescale 1ns/1ns
module tb;
    logic clk_i = 1'b0;
    logic reset_n_i = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hready, hresp, txd, rxd, cts, dsr, rts, dtr, bad, paused;
    logic [1:0] hbusy = 2'h0;
    logic [10:0] cfg = 11'h008;
    logic [31:0] rd;
    logic [7:0] got;
    int cnt, c0, n;
    int miscompares = 0;
    int checks = 0;
    // Rows: control word, byte written, byte the host must see
    logic [26:0] rows [7] = '{{11'h008, 8'hA5, 8'hA5}, {11'h001, 8'hC3, 8'h43},
        {11'h02A, 8'h37, 8'h37}, {11'h05B, 8'h80, 8'h80},
        {11'h034, 8'hFF, 8'h7F}, {11'h044, 8'h00, 8'h00},
        {11'h01F, 8'h5A, 8'h5A}};
    always #4 clk_i = ~clk_i;
    spf_uart #(.CLK_HZ(1152000)) i_dut(.clk_i(clk_i), .reset_n_i(reset_n_i),
        .ce_i(1'b1), .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans),
        .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
        .hready_i(hready), .hrdata_o(hrdata), .hreadyout_o(hready),
        .hresp_o(hresp), .rxd_i(rxd), .cts_i(cts), .dsr_i(dsr),
        .txd_o(txd), .rts_o(rts), .dtr_o(dtr));
    spf_host #(.CLK_HZ(1152000)) i_host(.clk_i(clk_i), .cfg_i(cfg),
        .busy_i(hbusy), .txd_i(txd), .rxd_o(rxd), .cts_o(cts), .dsr_o(dsr),
        .got_o(got), .bad_o(bad), .paused_o(paused), .count_o(cnt));
    // ==========================================
    // Shared tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("FAIL %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    task automatic limit(input int k, input int m);
        if (k >= m) begin
            miscompares++;
            close_out();
        end
    endtask
    task automatic ready_edge();
        int k;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (hready !== 1'b1 && k < 1000);
        limit(k, 1000);
    endtask
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {24'h0, a};
        hwrite <= wr;
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        ready_edge();
        rd = hrdata;
    endtask
    task automatic expect_rx(input logic [7:0] e);
        int k;
        k = 0;
        c0 = cnt;
        while (cnt == c0 && k < 5000) begin
            @(posedge clk_i);
            k++;
        end
        limit(k, 5000);
        check({23'h0, bad, got}, {24'h0, e});
    endtask
    // ==========================================
    initial begin
        repeat (6) @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        check({28'h0, txd, rts, dtr, hresp}, 32'h8);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h008);
        bus(1'b0, 8'h10, 32'h0);
        check(rd, 32'h0);
        $display("test reset done");
        for (int i = 0; i < 7; i++) begin
            cfg <= rows[i][26:16];
            bus(1'b1, 8'h00, {21'h0, rows[i][26:16]});
            bus(1'b1, 8'h08, {24'h0, rows[i][15:8]});
            expect_rx(rows[i][7:0]);
            check({30'h0, rts, dtr}, 32'h0);
        end
        $display("test formats done");
        cfg <= 11'h00C;
        bus(1'b1, 8'h00, 32'h68C);
        expect_rx(8'h13);
        check({31'h0, paused}, 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h200, 32'h200);
        bus(1'b1, 8'h00, 32'h28C);
        bus(1'b1, 8'h08, 32'h55);
        expect_rx(8'h11);
        check({31'h0, paused}, 32'h0);
        expect_rx(8'h55);
        check({30'h0, rts, dtr}, 32'h3);
        $display("test software flow done");
        hbusy <= 2'b01;
        bus(1'b1, 8'h00, 32'h30C);
        for (int i = 0; i < 8; i++) bus(1'b1, 8'h08, 32'hA0 + 32'(i));
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h6, 32'h2);
        c0 = cnt;
        repeat (300) @(posedge clk_i);
        check(32'(cnt), 32'(c0));
        hbusy <= 2'b10;
        repeat (300) @(posedge clk_i);
        check(32'(cnt), 32'(c0));
        // A ninth write stalls on the full buffer until the host frees it
        fork
            bus(1'b1, 8'h08, 32'hA8);
            begin
                repeat (20) @(posedge clk_i);
                hbusy <= 2'b00;
            end
        join
        for (int i = 0; i < 9; i++) expect_rx(8'hA0 + 8'(i));
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h6, 32'h4);
        $display("test hardware flow done");
        i_host.send(8'h3C);
        rd = 32'h0;
        for (n = 0; n < 200 && rd[0] !== 1'b1; n++) bus(1'b0, 8'h04, 32'h0);
        limit(n, 200);
        bus(1'b0, 8'h0C, 32'h0);
        check(rd, 32'h3C);
        $display("test receive done");
        i_host.send(8'h01);
        i_host.send(8'h02);
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h9, 32'h9);
        bus(1'b1, 8'h04, 32'h8);
        bus(1'b0, 8'h04, 32'h0);
        check(rd & 32'h9, 32'h1);
        $display("test overrun done");
        reset_n_i <= 1'b0;
        @(posedge clk_i);
        reset_n_i <= 1'b1;
        @(posedge clk_i);
        check({28'h0, txd, rts, dtr, hresp}, 32'h8);
        bus(1'b0, 8'h00, 32'h0);
        check(rd, 32'h008);
        $display("test second reset done");
        close_out();
    end
endmodule
